// >>> include/aof_params.svh
`ifndef AOF_PARAMS_SVH
`define AOF_PARAMS_SVH

// Register byte offsets on the Wishbone bus.
`define AOF_OFS_CLOCK_CTRL 8'h00
`define AOF_OFS_OUTPUT_CTRL 8'h04
`define AOF_OFS_STATUS 8'h08

// Clock control register fields.
`define AOF_CC_PHASE_LSB 0
`define AOF_CC_PHASE_MSB 1
`define AOF_CC_INVERT_BIT 2
`define AOF_CC_STAB_BIT 3

// Output control register fields.
`define AOF_OC_MODE_LSB 0
`define AOF_OC_MODE_MSB 1
`define AOF_OC_CUR_LSB 2
`define AOF_OC_CUR_MSB 4
`define AOF_OC_TERM_BIT 5

// Status register fields.
`define AOF_ST_PERIOD_LSB 0
`define AOF_ST_PERIOD_MSB 7
`define AOF_ST_MODE_LSB 8
`define AOF_ST_MODE_MSB 9
`define AOF_ST_PIN_CFG_BIT 10

// Reset values and the refused current code.
`define AOF_RST_PHASE 2'h0
`define AOF_RST_CURRENT 3'h4
`define AOF_CUR_ILLEGAL 3'h7

// Word and timing figures.
`define AOF_WORD_BITS 16
`define AOF_PAIR_LINES 8
`define AOF_LATENCY 4
`define AOF_PERIOD_BITS 8
`define AOF_PERIOD_MAX 8'hff
`define AOF_PHASE_STEPS_LOG2 3
`define AOF_DELAY_TAPS 16
`define AOF_SYNC_BITS 5

`endif

// >>> include/aof_pkg.sv
package aof_pkg;

  // Output format, Gray coded from full rate through the two double rate modes.
  typedef enum logic [1:0] {
    AOF_MODE_FULL = 2'b00,
    AOF_MODE_DDR_CMOS = 2'b01,
    AOF_MODE_DDR_LVDS = 2'b11
  } aof_mode_e;

  typedef logic [15:0] aof_word_t;

endpackage

// >>> hdl/aof_sample_pipe.sv
`timescale 1ns/1ns
`default_nettype none

module aof_sample_pipe #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Stream.
  input wire logic i_adv,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_data
);

  logic [WIDTH-1:0] stage_q [DEPTH];
  logic [WIDTH-1:0] stage_d [DEPTH];

  // On every encode event the first stage takes the input and each later stage the one before it.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_stage
      if (g == 0) begin : g_first
        always_comb begin
          stage_d[g] = i_adv ? i_data : stage_q[g];
        end
      end else begin : g_rest
        always_comb begin
          stage_d[g] = i_adv ? stage_q[g-1] : stage_q[g];
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          stage_q[g] <= '0;
        end else begin
          stage_q[g] <= stage_d[g];
        end
      end
    end
  endgenerate

  assign o_data = stage_q[DEPTH-1];

endmodule
`default_nettype wire

// >>> hdl/aof_formatter.sv
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "aof_params.svh"

module aof_formatter (
  // Clock and reset.
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Wishbone slave.
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Converter core results, on I_CLK.
  input wire aof_pkg::aof_word_t I_CH1_SAMPLE,
  input wire aof_pkg::aof_word_t I_CH2_SAMPLE,
  input wire logic I_CH1_OVR,
  input wire logic I_CH2_OVR,
  // Encode pins and pin-level configuration.
  input wire logic I_SAMPLE_STROBE_P,
  input wire logic I_SAMPLE_STROBE_N,
  input wire logic I_PIN_CFG_SEL,
  input wire logic I_PIN_LVDS_SEL,
  input wire logic I_PIN_STAB_EN,
  // Full rate outputs.
  output logic [15:0] O_CH1_WORD_LINES,
  output logic [15:0] O_CH2_WORD_LINES,
  output logic O_CH1_RANGE_FLAG,
  output logic O_CH2_RANGE_FLAG,
  // Double data rate outputs.
  output logic [7:0] O_CH1_PAIRED_LINES,
  output logic [7:0] O_CH1_PAIRED_LINES_N,
  output logic [7:0] O_CH2_PAIRED_LINES,
  output logic [7:0] O_CH2_PAIRED_LINES_N,
  output logic O_SHARED_RANGE_FLAG,
  output logic O_SHARED_RANGE_FLAG_N,
  // Forwarded clock and driver settings.
  output logic O_FWD_CLOCK_P,
  output logic O_FWD_CLOCK_N,
  output logic O_LVDS_EN,
  output logic [2:0] O_LVDS_CURRENT,
  output logic O_LVDS_TERM
);
  import aof_pkg::*;

  localparam int PW = `AOF_PERIOD_BITS;
  localparam int SW = 2 * `AOF_WORD_BITS + 2;

  // Pin synchroniser, two flip-flops per input.
  logic [`AOF_SYNC_BITS-1:0] sync1_q, sync2_q;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {I_PIN_STAB_EN, I_PIN_LVDS_SEL, I_PIN_CFG_SEL,
                  I_SAMPLE_STROBE_N, I_SAMPLE_STROBE_P};
      sync2_q <= sync1_q;
    end
  end

  // Encode level: differential, or single ended with the complement held low.
  logic enc_lvl, enc_prev_q, enc_ev;
  logic pin_cfg_q, pin_cfg_d;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  assign enc_lvl = sync2_q[0] & ~sync2_q[1];
  assign enc_ev = enc_lvl & ~enc_prev_q;

  // The strap is caught once, when the synchroniser first holds it after reset release.
  always_comb begin
    strap_cnt_d = (strap_cnt_q == 2'h3) ? strap_cnt_q : strap_cnt_q + 2'h1;
    pin_cfg_d = (strap_cnt_q == 2'h2) ? sync2_q[2] : pin_cfg_q;
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      enc_prev_q <= 1'b0;
      strap_cnt_q <= 2'h0;
      pin_cfg_q <= 1'b0;
    end else begin
      enc_prev_q <= enc_lvl;
      strap_cnt_q <= strap_cnt_d;
      pin_cfg_q <= pin_cfg_d;
    end
  end

  // Configuration registers written by the host.
  logic [1:0] phase_q, phase_d;
  logic invert_q, invert_d, stab_q, stab_d;
  aof_mode_e reg_mode_q, reg_mode_d;
  logic [2:0] cur_q, cur_d;
  logic term_q, term_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [PW-1:0] period_q;
  aof_mode_e mode_q;
  logic wb_req, wb_wr;
  assign wb_req = I_WB_CYC & I_WB_STB & ~ack_q;
  assign wb_wr = wb_req & I_WB_WE & I_WB_SEL[0];

  // Register writes and read mux; every access is answered one cycle later.
  always_comb begin
    phase_d = phase_q;
    invert_d = invert_q;
    stab_d = stab_q;
    reg_mode_d = reg_mode_q;
    cur_d = cur_q;
    term_d = term_q;
    ack_d = wb_req;
    rdat_d = rdat_q;
    if (wb_wr && I_WB_ADR == `AOF_OFS_CLOCK_CTRL) begin
      phase_d = I_WB_DAT[`AOF_CC_PHASE_MSB:`AOF_CC_PHASE_LSB];
      invert_d = I_WB_DAT[`AOF_CC_INVERT_BIT];
      stab_d = I_WB_DAT[`AOF_CC_STAB_BIT];
    end
    if (wb_wr && I_WB_ADR == `AOF_OFS_OUTPUT_CTRL) begin
      if (I_WB_DAT[`AOF_OC_MODE_MSB:`AOF_OC_MODE_LSB] != 2'b10) begin
        reg_mode_d = aof_mode_e'(I_WB_DAT[`AOF_OC_MODE_MSB:`AOF_OC_MODE_LSB]);
      end
      if (I_WB_DAT[`AOF_OC_CUR_MSB:`AOF_OC_CUR_LSB] != `AOF_CUR_ILLEGAL) begin
        cur_d = I_WB_DAT[`AOF_OC_CUR_MSB:`AOF_OC_CUR_LSB];
      end
      term_d = I_WB_DAT[`AOF_OC_TERM_BIT];
    end
    if (wb_req && !I_WB_WE) begin
      rdat_d = 32'h0;
      unique case (I_WB_ADR)
        `AOF_OFS_CLOCK_CTRL: begin
          rdat_d[`AOF_CC_PHASE_MSB:`AOF_CC_PHASE_LSB] = phase_q;
          rdat_d[`AOF_CC_INVERT_BIT] = invert_q;
          rdat_d[`AOF_CC_STAB_BIT] = stab_q;
        end
        `AOF_OFS_OUTPUT_CTRL: begin
          rdat_d[`AOF_OC_MODE_MSB:`AOF_OC_MODE_LSB] = reg_mode_q;
          rdat_d[`AOF_OC_CUR_MSB:`AOF_OC_CUR_LSB] = cur_q;
          rdat_d[`AOF_OC_TERM_BIT] = term_q;
        end
        `AOF_OFS_STATUS: begin
          rdat_d[`AOF_ST_PERIOD_MSB:`AOF_ST_PERIOD_LSB] = period_q;
          rdat_d[`AOF_ST_MODE_MSB:`AOF_ST_MODE_LSB] = mode_q;
          rdat_d[`AOF_ST_PIN_CFG_BIT] = pin_cfg_q;
        end
        default: begin
          rdat_d = 32'h0;
        end
      endcase
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      phase_q <= `AOF_RST_PHASE;
      invert_q <= 1'b0;
      stab_q <= 1'b0;
      reg_mode_q <= AOF_MODE_FULL;
      cur_q <= `AOF_RST_CURRENT;
      term_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      phase_q <= phase_d;
      invert_q <= invert_d;
      stab_q <= stab_d;
      reg_mode_q <= reg_mode_d;
      cur_q <= cur_d;
      term_q <= term_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end
  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

  // Effective settings: pin configuration offers only full rate or differential DDR.
  aof_mode_e eff_mode;
  logic eff_stab;
  always_comb begin
    if (pin_cfg_q) begin
      eff_mode = sync2_q[3] ? AOF_MODE_DDR_LVDS : AOF_MODE_FULL;
      eff_stab = sync2_q[4];
    end else begin
      eff_mode = reg_mode_q;
      eff_stab = stab_q;
    end
  end

  // Both channels enter one pipeline on the same encode event.
  logic [SW-1:0] pipe_out;
  aof_sample_pipe #(
    .WIDTH(SW),
    .DEPTH(`AOF_LATENCY)
  ) u_pipe (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_adv(enc_ev),
    .i_data({I_CH2_OVR, I_CH1_OVR, I_CH2_SAMPLE, I_CH1_SAMPLE}),
    .o_data(pipe_out)
  );

  // Encode period measurement and position within the current period.
  logic [PW-1:0] cnt_q, cnt_d, period_d, cnt_inc;
  logic [SW-1:0] cur_w_q, cur_w_d;
  logic hi_q, hi_d;
  aof_mode_e mode_d;
  assign cnt_inc = (cnt_q == `AOF_PERIOD_MAX) ? cnt_q : cnt_q + PW'(1);
  always_comb begin
    cnt_d = enc_ev ? '0 : cnt_inc;
    period_d = enc_ev ? cnt_inc : period_q;
    cur_w_d = enc_ev ? pipe_out : cur_w_q;
    mode_d = enc_ev ? eff_mode : mode_q;
    // The second half of each period is the high phase of the output clock.
    hi_d = !enc_ev && (period_q != '0) && (cnt_d >= (period_q >> 1));
  end
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      cnt_q <= '0;
      period_q <= '0;
      cur_w_q <= '0;
      hi_q <= 1'b0;
      mode_q <= AOF_MODE_FULL;
    end else begin
      cnt_q <= cnt_d;
      period_q <= period_d;
      cur_w_q <= cur_w_d;
      hi_q <= hi_d;
      mode_q <= mode_d;
    end
  end

  // Clock delay line: phase steps of one eighth period, only with stabilizer on.
  logic [`AOF_DELAY_TAPS-3:0] dly_q, dly_d;
  logic [`AOF_DELAY_TAPS-1:0] hist;
  logic [PW+1:0] prod;
  logic [3:0] tap;
  assign prod = (PW + 2)'(period_q) * (PW + 2)'(phase_q);
  assign hist = {dly_q, hi_q, hi_d};
  always_comb begin
    dly_d = {dly_q[`AOF_DELAY_TAPS-4:0], hi_q};
    if (!eff_stab) begin
      tap = 4'h0;
    end else if ((prod >> `AOF_PHASE_STEPS_LOG2) > (PW + 2)'(`AOF_DELAY_TAPS - 1)) begin
      tap = 4'hf;
    end else begin
      tap = 4'(prod >> `AOF_PHASE_STEPS_LOG2);
    end
  end

  // Output word formatting for the next cycle.
  logic [15:0] w1_d, w2_d;
  logic [7:0] p1_d, p2_d;
  logic f1_d, f2_d, fs_d, clk_d, lvds_d;
  aof_word_t w1, w2;
  assign w1 = cur_w_d[15:0];
  assign w2 = cur_w_d[31:16];
  always_comb begin
    w1_d = 16'h0;
    w2_d = 16'h0;
    f1_d = 1'b0;
    f2_d = 1'b0;
    fs_d = 1'b0;
    p1_d = 8'h0;
    p2_d = 8'h0;
    lvds_d = (mode_d == AOF_MODE_DDR_LVDS);
    clk_d = hist[tap] ^ invert_q;
    if (mode_d == AOF_MODE_FULL) begin
      w1_d = w1;
      w2_d = w2;
      f1_d = cur_w_d[32];
      f2_d = cur_w_d[33];
    end else begin
      for (int i = 0; i < `AOF_PAIR_LINES; i++) begin
        p1_d[i] = hi_d ? w1[2*i+1] : w1[2*i];
        p2_d[i] = hi_d ? w2[2*i+1] : w2[2*i];
      end
      fs_d = hi_d ? cur_w_d[32] : cur_w_d[33];
    end
  end

  // Output flip-flops; complements are registered from the same next value.
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      dly_q <= '0;
      O_CH1_WORD_LINES <= 16'h0;
      O_CH2_WORD_LINES <= 16'h0;
      O_CH1_RANGE_FLAG <= 1'b0;
      O_CH2_RANGE_FLAG <= 1'b0;
      O_CH1_PAIRED_LINES <= 8'h0;
      O_CH1_PAIRED_LINES_N <= 8'hff;
      O_CH2_PAIRED_LINES <= 8'h0;
      O_CH2_PAIRED_LINES_N <= 8'hff;
      O_SHARED_RANGE_FLAG <= 1'b0;
      O_SHARED_RANGE_FLAG_N <= 1'b1;
      O_FWD_CLOCK_P <= 1'b0;
      O_FWD_CLOCK_N <= 1'b1;
      O_LVDS_EN <= 1'b0;
      O_LVDS_CURRENT <= `AOF_RST_CURRENT;
      O_LVDS_TERM <= 1'b0;
    end else begin
      dly_q <= dly_d;
      O_CH1_WORD_LINES <= w1_d;
      O_CH2_WORD_LINES <= w2_d;
      O_CH1_RANGE_FLAG <= f1_d;
      O_CH2_RANGE_FLAG <= f2_d;
      O_CH1_PAIRED_LINES <= p1_d;
      O_CH1_PAIRED_LINES_N <= ~p1_d;
      O_CH2_PAIRED_LINES <= p2_d;
      O_CH2_PAIRED_LINES_N <= ~p2_d;
      O_SHARED_RANGE_FLAG <= fs_d;
      O_SHARED_RANGE_FLAG_N <= ~fs_d;
      O_FWD_CLOCK_P <= clk_d;
      O_FWD_CLOCK_N <= ~clk_d;
      O_LVDS_EN <= lvds_d;
      O_LVDS_CURRENT <= cur_q;
      O_LVDS_TERM <= lvds_d & term_q;
    end
  end

endmodule
`default_nettype wire

// >>> test/aof_formatter_props.sv
`timescale 1ns/1ns
`default_nettype none
module aof_formatter_props (
  // Watched ports.
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic O_WB_ACK,
  input wire logic [15:0] O_CH1_WORD_LINES,
  input wire logic O_CH1_RANGE_FLAG,
  input wire logic [7:0] O_CH1_PAIRED_LINES,
  input wire logic [7:0] O_CH1_PAIRED_LINES_N,
  input wire logic [7:0] O_CH2_PAIRED_LINES,
  input wire logic [7:0] O_CH2_PAIRED_LINES_N,
  input wire logic O_SHARED_RANGE_FLAG,
  input wire logic O_SHARED_RANGE_FLAG_N,
  input wire logic O_FWD_CLOCK_P,
  input wire logic O_FWD_CLOCK_N,
  input wire logic O_LVDS_EN,
  input wire logic O_LVDS_TERM
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // A bus request still waiting for its answer.
  sequence bus_req_s;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  // Differential mode held long enough for the next encode event to pass.
  sequence ddr_settled_s;
    O_LVDS_EN [*8] ##1 O_LVDS_EN;
  endsequence
  // The forwarded clock pair and the data pairs stay complementary.
  clk_inverse_a: assert property (O_FWD_CLOCK_N == !O_FWD_CLOCK_P)
    else $error("forwarded clock pair not complementary");
  pair_inverse_a: assert property ((O_CH1_PAIRED_LINES_N == ~O_CH1_PAIRED_LINES)
    && (O_CH2_PAIRED_LINES_N == ~O_CH2_PAIRED_LINES)) else $error("data pair not inverse");
  flag_inverse_a: assert property (O_SHARED_RANGE_FLAG_N == !O_SHARED_RANGE_FLAG)
    else $error("shared flag pair not inverse");
  // Bus answers exactly one cycle after the request and only for one cycle.
  ack_answer_a: assert property (bus_req_s |=> O_WB_ACK) else $error("bus ack late");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("bus ack too long");
  // Full rate words change only while the forwarded clock is low.
  full_edge_a: assert property ($changed(O_CH1_WORD_LINES) |-> !O_FWD_CLOCK_P)
    else $error("full rate word changed with clock high");
  ddr_quiet_a: assert property (ddr_settled_s |-> (O_CH1_WORD_LINES == 16'h0)
    && !O_CH1_RANGE_FLAG) else $error("full rate outputs active in ddr");
  term_gate_a: assert property (O_LVDS_TERM |-> O_LVDS_EN)
    else $error("termination outside differential mode");
endmodule
`default_nettype wire

// >>> test/aof_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module aof_rx_model (
  // Clock and forwarded link.
  input wire logic i_clk,
  input wire logic i_fwd_p,
  input wire logic [15:0] i_w1,
  input wire logic [15:0] i_w2,
  input wire logic i_f1,
  input wire logic i_f2,
  input wire logic [7:0] i_p1,
  input wire logic [7:0] i_p2,
  input wire logic i_sf,
  // Captured results.
  output logic [15:0] o_full1,
  output logic [15:0] o_full2,
  output logic [15:0] o_ddr1,
  output logic [15:0] o_ddr2,
  output logic o_ff1,
  output logic o_ff2,
  output logic o_sf1,
  output logic o_sf2
);
  logic fwd_q;
  logic sf_q;
  logic [7:0] p1_q, p2_q, e1_q, e2_q;
  // Capture on clock edges found by sampling, using pair line values from before the edge and full rate lines as seen with it.
  always @(posedge i_clk) begin
    fwd_q <= i_fwd_p;
    p1_q <= i_p1;
    p2_q <= i_p2;
    sf_q <= i_sf;
    if (i_fwd_p && !fwd_q) begin
      o_full1 <= i_w1;
      o_full2 <= i_w2;
      o_ff1 <= i_f1;
      o_ff2 <= i_f2;
      e1_q <= p1_q;
      e2_q <= p2_q;
      o_sf2 <= sf_q;
    end
    if (!i_fwd_p && fwd_q) begin
      for (int i = 0; i < 8; i++) begin
        o_ddr1[2*i] <= e1_q[i];
        o_ddr1[2*i+1] <= p1_q[i];
        o_ddr2[2*i] <= e2_q[i];
        o_ddr2[2*i+1] <= p2_q[i];
      end
      o_sf1 <= sf_q;
    end
  end
endmodule
`default_nettype wire

// >>> test/aof_formatter_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module aof_formatter_tb_top;
  import aof_pkg::*;
  logic I_CLK, I_SYS_RST, I_WB_CYC, I_WB_STB, I_WB_WE, I_CH1_OVR, I_CH2_OVR;
  logic I_SAMPLE_STROBE_P, I_SAMPLE_STROBE_N, I_PIN_CFG_SEL, I_PIN_LVDS_SEL, I_PIN_STAB_EN;
  logic [7:0] I_WB_ADR;
  logic [3:0] I_WB_SEL;
  logic [31:0] I_WB_DAT, O_WB_DAT, rdat;
  aof_word_t I_CH1_SAMPLE, I_CH2_SAMPLE;
  logic [15:0] O_CH1_WORD_LINES, O_CH2_WORD_LINES, full1, full2, ddr1, ddr2;
  logic [7:0] O_CH1_PAIRED_LINES, O_CH1_PAIRED_LINES_N, O_CH2_PAIRED_LINES, O_CH2_PAIRED_LINES_N;
  logic O_WB_ACK, O_CH1_RANGE_FLAG, O_CH2_RANGE_FLAG, O_SHARED_RANGE_FLAG, O_SHARED_RANGE_FLAG_N;
  logic O_FWD_CLOCK_P, O_FWD_CLOCK_N, O_LVDS_EN, O_LVDS_TERM, ff1, ff2, sf1, sf2;
  logic [2:0] O_LVDS_CURRENT, enc_cnt;
  int error_cnt, cmp_count;
  aof_formatter aof_formatter_i (.*);
  aof_rx_model aof_rx_model_i (.i_clk(I_CLK), .i_fwd_p(O_FWD_CLOCK_P), .i_w1(O_CH1_WORD_LINES),
    .i_w2(O_CH2_WORD_LINES), .i_f1(O_CH1_RANGE_FLAG), .i_f2(O_CH2_RANGE_FLAG),
    .i_p1(O_CH1_PAIRED_LINES), .i_p2(O_CH2_PAIRED_LINES), .i_sf(O_SHARED_RANGE_FLAG),
    .o_full1(full1), .o_full2(full2), .o_ddr1(ddr1), .o_ddr2(ddr2), .o_ff1(ff1), .o_ff2(ff2),
    .o_sf1(sf1), .o_sf2(sf2));
  // Clock, and an encode strobe of eight clock periods.
  initial begin
    I_CLK = 0;
    forever #25 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    enc_cnt <= enc_cnt + 3'h1;
    I_SAMPLE_STROBE_P <= enc_cnt[2];
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One classic bus cycle, held until the answer.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    I_WB_CYC <= 1;
    I_WB_STB <= 1;
    I_WB_WE <= w;
    I_WB_SEL <= 4'hf;
    I_WB_ADR <= a;
    I_WB_DAT <= d;
    do begin
      @(posedge I_CLK);
    end while (O_WB_ACK !== 1'b1);
    rdat = O_WB_DAT;
    I_WB_CYC <= 0;
    I_WB_STB <= 0;
    @(posedge I_CLK);
  endtask
  task automatic settle(input aof_word_t a, input aof_word_t b, input logic f1, input logic f2);
    I_CH1_SAMPLE <= a;
    I_CH2_SAMPLE <= b;
    I_CH1_OVR <= f1;
    I_CH2_OVR <= f2;
    repeat (80) @(posedge I_CLK);
  endtask
  task automatic t_regs();
    wb(0, 8'h04, 0);
    chk("out ctrl reset", rdat, 32'h10);
    wb(0, 8'h00, 0);
    chk("clk ctrl reset", rdat, 32'h0);
    wb(0, 8'h0c, 0);
    chk("unmapped read", rdat, 32'h0);
    chk("current pins", O_LVDS_CURRENT, 3'h4);
  endtask
  task automatic t_full();
    settle(16'h8001, 16'h4002, 1, 0);
    chk("full ch1", full1, 16'h8001);
    chk("full ch2", full2, 16'h4002);
    chk("full flags", {ff1, ff2}, 2'b10);
    chk("ddr quiet", O_CH1_PAIRED_LINES, 8'h0);
  endtask
  task automatic t_ddr(input logic [1:0] m);
    wb(1, 8'h04, (m == 2'h3) ? 32'h3b : 32'h11);
    settle(16'ha5c3, 16'h3c5a, 0, 1);
    chk("ddr ch1", ddr1, 16'ha5c3);
    chk("ddr ch2", ddr2, 16'h3c5a);
    chk("shared flag", {sf1, sf2}, 2'b01);
    chk("diff enable", O_LVDS_EN, m == 2'h3);
    chk("current", O_LVDS_CURRENT, (m == 2'h3) ? 3'h6 : 3'h4);
    chk("term", O_LVDS_TERM, m == 2'h3);
  endtask
  task automatic t_refuse();
    wb(1, 8'h04, 32'h3e);
    repeat (20) @(posedge I_CLK);
    chk("current 7 refused", O_LVDS_CURRENT, 3'h6);
    wb(0, 8'h08, 0);
    chk("status mode period", rdat[9:0], 10'h308);
  endtask
  // Cycles from the last data change to the forwarded clock rising.
  task automatic t_phase(input logic [31:0] v, input int e);
    int k = 0;
    logic [7:0] pv;
    logic fv;
    wb(1, 8'h00, v);
    repeat (80) @(posedge I_CLK);
    do begin
      pv = O_CH1_PAIRED_LINES;
      fv = O_FWD_CLOCK_P;
      @(posedge I_CLK);
      k = (O_CH1_PAIRED_LINES !== pv) ? 0 : k + 1;
    end while (!(O_FWD_CLOCK_P && !fv));
    chk("clock phase", k, e);
  endtask
  // Pin configuration after a second reset; a register mode write must not take over.
  task automatic t_pin();
    I_PIN_CFG_SEL <= 1;
    I_PIN_LVDS_SEL <= 1;
    I_SYS_RST <= 1;
    repeat (4) @(posedge I_CLK);
    I_SYS_RST <= 0;
    wb(1, 8'h04, 32'h1);
    settle(16'h1234, 16'h8765, 1, 0);
    wb(0, 8'h08, 0);
    chk("pin status", rdat[10:8], 3'h7);
    chk("pin ddr ch1", ddr1, 16'h1234);
    chk("pin ddr ch2", ddr2, 16'h8765);
    chk("pin shared flag", {sf1, sf2}, 2'b10);
    chk("pin diff enable", O_LVDS_EN, 1'b1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
  // Reset, then the scenarios in turn.
  initial begin
    {I_WB_CYC, I_WB_STB, I_WB_WE, I_CH1_OVR, I_CH2_OVR, I_SAMPLE_STROBE_P} = 0;
    {I_SAMPLE_STROBE_N, I_PIN_CFG_SEL, I_PIN_LVDS_SEL, I_PIN_STAB_EN} = 0;
    {I_WB_ADR, I_WB_DAT, I_CH1_SAMPLE, I_CH2_SAMPLE, enc_cnt} = 0;
    I_WB_SEL = 4'hf;
    I_SYS_RST = 1;
    repeat (4) @(posedge I_CLK);
    I_SYS_RST <= 0;
    t_regs();
    t_full();
    t_ddr(2'h1);
    t_ddr(2'h3);
    t_refuse();
    t_phase(32'h2, 0);
    t_phase(32'ha, 2);
    t_pin();
    close_out();
  end
endmodule
bind aof_formatter aof_formatter_props aof_formatter_props_i (.*);
`default_nettype wire
